// file: include/plc_defines.svh
// Register offsets, reset values and sizes of the parallel line controller
`ifndef PLC_DEFINES_SVH
`define PLC_DEFINES_SVH

`define PLC_LINES 32
`define PLC_ADDR_W 8
`define PLC_DATA_W 32

`define PLC_OFF_OUTPUT_ENABLE_SET 8'h10
`define PLC_OFF_OUTPUT_ENABLE_CLEAR 8'h14
`define PLC_OFF_OUTPUT_ENABLE_STATE 8'h18
`define PLC_OFF_GLITCH_FILTER_ON 8'h20
`define PLC_OFF_GLITCH_FILTER_OFF 8'h24
`define PLC_OFF_GLITCH_FILTER_STATE 8'h28
`define PLC_OFF_DRIVE_LEVEL_HIGH 8'h30
`define PLC_OFF_DRIVE_LEVEL_LOW 8'h34
`define PLC_OFF_DRIVE_LEVEL_STATE 8'h38
`define PLC_OFF_PIN_LEVEL_SAMPLE 8'h3C
`define PLC_OFF_CHANGE_IRQ_ON 8'h40
`define PLC_OFF_CHANGE_IRQ_OFF 8'h44
`define PLC_OFF_CHANGE_IRQ_MASK 8'h48
`define PLC_OFF_CHANGE_IRQ_FLAGS 8'h4C
`define PLC_OFF_OPEN_DRAIN_ON 8'h50
`define PLC_OFF_OPEN_DRAIN_OFF 8'h54
`define PLC_OFF_OPEN_DRAIN_STATE 8'h58
`define PLC_OFF_DIRECT_WRITE_ON 8'hA0
`define PLC_OFF_DIRECT_WRITE_OFF 8'hA4
`define PLC_OFF_DIRECT_WRITE_PERMISSION_STATE 8'hA8

`define PLC_RST_OUTPUT_ENABLE 32'h00000000
`define PLC_RST_GLITCH_FILTER 32'h00000000
`define PLC_RST_DRIVE_LEVEL 32'h00000000
`define PLC_RST_CHANGE_IRQ_MASK 32'h00000000
`define PLC_RST_CHANGE_IRQ_FLAGS 32'h00000000
`define PLC_RST_OPEN_DRAIN 32'h00000000
`define PLC_RST_DIRECT_WRITE 32'h00000000
`define PLC_RST_READ_DATA 32'h00000000
`define PLC_RST_LINE_LEVEL 32'h00000000

`endif

// file: include/plc_pkg.sv
// Types shared by the parallel line controller files
package plc_pkg;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } plc_bus_req_t;

    typedef struct packed {
        logic [31:0] level;
        logic [31:0] oe_n;
    } plc_pad_drive_t;

    typedef struct packed {
        logic [31:0] output_enable;
        logic [31:0] glitch_filter;
        logic [31:0] drive_level;
        logic [31:0] change_irq_mask;
        logic [31:0] change_irq_flags;
        logic [31:0] open_drain;
        logic [31:0] direct_write;
    } plc_state_t;

endpackage

// file: src/plc_line_filter.sv
// Per-line pin synchroniser, optional glitch filter and change detector
`timescale 1ns/100ps
module plc_line_filter #(
    parameter int LINES = 32
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [LINES-1:0] pin_in,
    input wire logic [LINES-1:0] filter_on_in,
    output logic [LINES-1:0] level_out,
    output logic [LINES-1:0] change_out
);

    logic [LINES-1:0] sync1;
    logic [LINES-1:0] sync2;
    logic [LINES-1:0] sync3;
    logic [LINES-1:0] pending;
    logic [LINES-1:0] next_pending;
    logic [LINES-1:0] next_level;
    logic [LINES-1:0] next_change;

    genvar i;
    generate
        for (i = 0; i < LINES; i++)
        begin : g_line
            // Stage one is read only by stage two
            always_comb
            begin
                next_level[i] = level_out[i];
                next_pending[i] = 1'b0;
                next_change[i] = 1'b0;
                if ((sync2[i] == sync3[i]) && (sync3[i] != level_out[i]))
                begin
                    // A filtered line must hold the new level for three agreeing samples
                    if (!filter_on_in[i] || pending[i])
                    begin
                        next_level[i] = sync3[i];
                        next_change[i] = 1'b1;
                    end
                    else
                    begin
                        next_pending[i] = 1'b1;
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            sync1 <= '0;
            sync2 <= '0;
            sync3 <= '0;
            pending <= '0;
            level_out <= '0;
            change_out <= '0;
        end
        else
        begin
            sync1 <= pin_in;
            sync2 <= sync1;
            sync3 <= sync2;
            pending <= next_pending;
            level_out <= next_level;
            change_out <= next_change;
        end
    end

endmodule

// file: src/plc_top.sv
// Parallel line controller: register slave, line drivers and change flags
//
// How it works
// - Writing one to output_enable_set enables driver.
// - Writing one to output_enable_clear disables driver.
// - output_enable_state reads one per enabled driver.
// - Writing one to glitch_filter_on enables filter.
// - Writing one to glitch_filter_off disables filter.
// - glitch_filter_state reads one per filtered line.
// - Writing one to drive_level_high sets level.
// - Writing one to drive_level_low clears level.
// - drive_level_state reports scheduled drive level.
// - drive_level_state writable only on permitted lines.
// - pin_level_sample returns sampled pin level.
// - Writing one to change_irq_on enables interrupt.
// - Writing one to change_irq_off disables interrupt.
// - change_irq_mask reads one per enabled interrupt.
// - Pin level change sets its flag.
// - Flags read zero unchanged; reading clears them.
// - Writing one to open_drain_on enables multi-drive.
// - Multi-drive lines only pull low.
`timescale 1ns/100ps
`include "plc_defines.svh"
module plc_top (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [7:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [31:0] rdata_out,
    input wire logic [31:0] line_bits_in,
    output logic [31:0] line_bits_out,
    output logic [31:0] line_bits_oe_n_out,
    output logic irq_out
);

    plc_pkg::plc_bus_req_t req;
    plc_pkg::plc_state_t st;
    plc_pkg::plc_state_t next_st;
    plc_pkg::plc_pad_drive_t pad;
    plc_pkg::plc_pad_drive_t next_pad;
    logic [31:0] next_rdata;
    logic [31:0] pin_level;
    logic [31:0] pin_change;
    logic wr_hit;

    assign req.addr = addr_in;
    assign req.wdata = wdata_in;
    assign req.wr = wr_in;
    assign req.rd = rd_in;

    plc_line_filter #(
        .LINES(`PLC_LINES)
    ) u_filter (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .pin_in(line_bits_in),
        .filter_on_in(st.glitch_filter),
        .level_out(pin_level),
        .change_out(pin_change)
    );

    // Register writes: every command register only touches bits written as one
    always_comb
    begin
        next_st = st;
        wr_hit = 1'b0;
        if (req.wr)
        begin
            if (req.addr == `PLC_OFF_OUTPUT_ENABLE_SET)
            begin
                next_st.output_enable = st.output_enable | req.wdata;
                wr_hit = 1'b1;
            end
            else if (req.addr == `PLC_OFF_OUTPUT_ENABLE_CLEAR)
            begin
                next_st.output_enable = st.output_enable & ~req.wdata;
                wr_hit = 1'b1;
            end
            else if (req.addr == `PLC_OFF_GLITCH_FILTER_ON)
            begin
                next_st.glitch_filter = st.glitch_filter | req.wdata;
                wr_hit = 1'b1;
            end
            else if (req.addr == `PLC_OFF_GLITCH_FILTER_OFF)
            begin
                next_st.glitch_filter = st.glitch_filter & ~req.wdata;
                wr_hit = 1'b1;
            end
            else if (req.addr == `PLC_OFF_DRIVE_LEVEL_HIGH)
            begin
                next_st.drive_level = st.drive_level | req.wdata;
                wr_hit = 1'b1;
            end
            else if (req.addr == `PLC_OFF_DRIVE_LEVEL_LOW)
            begin
                next_st.drive_level = st.drive_level & ~req.wdata;
                wr_hit = 1'b1;
            end
            else if (req.addr == `PLC_OFF_DRIVE_LEVEL_STATE)
            begin
                // Lines without write permission keep their level
                next_st.drive_level = (st.drive_level & ~st.direct_write)
                    | (req.wdata & st.direct_write);
                wr_hit = 1'b1;
            end
            else if (req.addr == `PLC_OFF_CHANGE_IRQ_ON)
            begin
                next_st.change_irq_mask = st.change_irq_mask | req.wdata;
                wr_hit = 1'b1;
            end
            else if (req.addr == `PLC_OFF_CHANGE_IRQ_OFF)
            begin
                next_st.change_irq_mask = st.change_irq_mask & ~req.wdata;
                wr_hit = 1'b1;
            end
            else if (req.addr == `PLC_OFF_OPEN_DRAIN_ON)
            begin
                next_st.open_drain = st.open_drain | req.wdata;
                wr_hit = 1'b1;
            end
            else if (req.addr == `PLC_OFF_OPEN_DRAIN_OFF)
            begin
                next_st.open_drain = st.open_drain & ~req.wdata;
                wr_hit = 1'b1;
            end
            else if (req.addr == `PLC_OFF_DIRECT_WRITE_ON)
            begin
                next_st.direct_write = st.direct_write | req.wdata;
                wr_hit = 1'b1;
            end
            else if (req.addr == `PLC_OFF_DIRECT_WRITE_OFF)
            begin
                next_st.direct_write = st.direct_write & ~req.wdata;
                wr_hit = 1'b1;
            end
            else
            begin
                // Status offsets and unmapped offsets ignore writes
                wr_hit = 1'b0;
            end
        end
        // A read clears the flags, but a change in the same cycle survives the clear
        if (req.rd && (req.addr == `PLC_OFF_CHANGE_IRQ_FLAGS))
        begin
            next_st.change_irq_flags = pin_change;
        end
        else
        begin
            next_st.change_irq_flags = st.change_irq_flags | pin_change;
        end
    end

    // Read multiplexer; data are valid only in the cycle after the strobe
    always_comb
    begin
        next_rdata = `PLC_RST_READ_DATA;
        if (req.rd)
        begin
            if (req.addr == `PLC_OFF_OUTPUT_ENABLE_STATE)
            begin
                next_rdata = st.output_enable;
            end
            else if (req.addr == `PLC_OFF_GLITCH_FILTER_STATE)
            begin
                next_rdata = st.glitch_filter;
            end
            else if (req.addr == `PLC_OFF_DRIVE_LEVEL_STATE)
            begin
                next_rdata = st.drive_level;
            end
            else if (req.addr == `PLC_OFF_PIN_LEVEL_SAMPLE)
            begin
                next_rdata = pin_level;
            end
            else if (req.addr == `PLC_OFF_CHANGE_IRQ_MASK)
            begin
                next_rdata = st.change_irq_mask;
            end
            else if (req.addr == `PLC_OFF_CHANGE_IRQ_FLAGS)
            begin
                next_rdata = st.change_irq_flags;
            end
            else if (req.addr == `PLC_OFF_OPEN_DRAIN_STATE)
            begin
                next_rdata = st.open_drain;
            end
            else if (req.addr == `PLC_OFF_DIRECT_WRITE_PERMISSION_STATE)
            begin
                next_rdata = st.direct_write;
            end
            else
            begin
                // Write-only and unmapped offsets read as zero
                next_rdata = `PLC_RST_READ_DATA;
            end
        end
    end

    // Pad drive: an open-drain line releases the pin instead of driving high
    always_comb
    begin
        next_pad.level = next_st.drive_level & ~next_st.open_drain;
        next_pad.oe_n = ~(next_st.output_enable
            & ~(next_st.open_drain & next_st.drive_level));
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            st.output_enable <= `PLC_RST_OUTPUT_ENABLE;
            st.glitch_filter <= `PLC_RST_GLITCH_FILTER;
            st.drive_level <= `PLC_RST_DRIVE_LEVEL;
            st.change_irq_mask <= `PLC_RST_CHANGE_IRQ_MASK;
            st.change_irq_flags <= `PLC_RST_CHANGE_IRQ_FLAGS;
            st.open_drain <= `PLC_RST_OPEN_DRAIN;
            st.direct_write <= `PLC_RST_DIRECT_WRITE;
            pad.level <= `PLC_RST_DRIVE_LEVEL;
            pad.oe_n <= ~`PLC_RST_OUTPUT_ENABLE;
            rdata_out <= `PLC_RST_READ_DATA;
        end
        else
        begin
            st <= next_st;
            pad <= next_pad;
            rdata_out <= next_rdata;
        end
    end

    assign line_bits_out = pad.level;
    assign line_bits_oe_n_out = pad.oe_n;
    // Level request; it drops only once software has read the flags or masked them
    assign irq_out = |(st.change_irq_flags & st.change_irq_mask);

endmodule

// file: test/plc_top_asserts.sv
// Port checker for the parallel line controller
`timescale 1ns/100ps
`include "plc_defines.svh"
module plc_top_asserts (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [7:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [31:0] rdata_out,
    input wire logic [31:0] line_bits_in,
    input wire logic [31:0] line_bits_out,
    input wire logic [31:0] line_bits_oe_n_out,
    input wire logic irq_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);
    a_enable_drives:
        assert property (wr_in && addr_in == `PLC_OFF_OUTPUT_ENABLE_SET
            |=> (line_bits_oe_n_out & $past(wdata_in) & line_bits_out) == 32'h0) else $error("line not driven");
    a_disable_frees:
        assert property (wr_in && addr_in == `PLC_OFF_OUTPUT_ENABLE_CLEAR
            |=> (~line_bits_oe_n_out & $past(wdata_in)) == 32'h0) else $error("line still driven");
    a_high_not_low:
        assert property (wr_in && addr_in == `PLC_OFF_DRIVE_LEVEL_HIGH
            |=> (~line_bits_out & ~line_bits_oe_n_out & $past(wdata_in)) == 32'h0) else $error("line driven low");
    a_low_clears:
        assert property (wr_in && addr_in == `PLC_OFF_DRIVE_LEVEL_LOW
            |=> (line_bits_out & $past(wdata_in)) == 32'h0) else $error("line still high");
    a_open_drain_low:
        assert property (wr_in && addr_in == `PLC_OFF_OPEN_DRAIN_ON
            |=> (line_bits_out & $past(wdata_in)) == 32'h0) else $error("open drain line driven high");
    a_zero_no_effect:
        assert property (wr_in && addr_in == `PLC_OFF_OUTPUT_ENABLE_SET
            |=> (line_bits_oe_n_out & ~$past(wdata_in)) == ($past(line_bits_oe_n_out) & ~$past(wdata_in)))
            else $error("zero bit changed a line");
    a_irq_all_off:
        assert property (wr_in && addr_in == `PLC_OFF_CHANGE_IRQ_OFF && wdata_in == 32'hFFFFFFFF
            |=> !irq_out) else $error("interrupt after full disable");
    a_pin_sample:
        assert property ($stable(line_bits_in)[*7] ##0 (rd_in && addr_in == `PLC_OFF_PIN_LEVEL_SAMPLE)
            |=> rdata_out == $past(line_bits_in)) else $error("pin sample wrong");
endmodule
bind plc_top plc_top_asserts u_chk (.clk_in, .rst_n_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
    .line_bits_in, .line_bits_out, .line_bits_oe_n_out, .irq_out);

// file: test/plc_pad_model.sv
// Behavioural pads and external drivers on the line pins
`timescale 1ns/100ps
module plc_pad_model (
    input wire logic [31:0] oe_n_in,
    input wire logic [31:0] level_in,
    input wire logic [31:0] ext_in,
    input wire logic [31:0] ext_en_in,
    output logic [31:0] pin_out
);
    // Undriven lines follow an enabled external driver, else float to the pull-up and read back as one
    assign pin_out = (~oe_n_in & level_in) | (oe_n_in & ((ext_en_in & ext_in) | ~ext_en_in));
endmodule

// file: test/tb.sv
// Self-checking bench for the parallel line controller
`timescale 1ns/100ps
`include "plc_defines.svh"
module tb;
    logic clk_in = 1'h0;
    logic rst_n_in = 1'h0;
    logic [7:0] addr_in = 8'h00;
    logic [31:0] wdata_in = 32'h0;
    logic wr_in = 1'h0;
    logic rd_in = 1'h0;
    logic [31:0] rdata_out, line_bits_in, line_bits_out, line_bits_oe_n_out;
    logic irq_out;
    logic [31:0] ext = 32'h0, ext_en = 32'hFFFFFFFF;
    logic [31:0] oe = 0, flt = 0, lvl = 0, msk = 0, od = 0, dw = 0, pin = 0, flg = 0, oen, outv, p;
    logic rd_q = 1'h0;
    logic [31:0] expq[$];
    logic [7:0] ops[16] = '{`PLC_OFF_OUTPUT_ENABLE_SET, `PLC_OFF_OUTPUT_ENABLE_CLEAR, `PLC_OFF_GLITCH_FILTER_ON,
        `PLC_OFF_GLITCH_FILTER_OFF, `PLC_OFF_DRIVE_LEVEL_HIGH, `PLC_OFF_DRIVE_LEVEL_LOW, `PLC_OFF_DRIVE_LEVEL_STATE,
        `PLC_OFF_CHANGE_IRQ_ON, `PLC_OFF_CHANGE_IRQ_OFF, `PLC_OFF_OPEN_DRAIN_ON, `PLC_OFF_OPEN_DRAIN_OFF,
        `PLC_OFF_DIRECT_WRITE_ON, `PLC_OFF_DIRECT_WRITE_OFF, `PLC_OFF_OUTPUT_ENABLE_STATE,
        `PLC_OFF_CHANGE_IRQ_FLAGS, 8'h0C};
    int n_fail = 0;
    int checks = 0;
    plc_top DUT (.clk_in, .rst_n_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .line_bits_in,
        .line_bits_out, .line_bits_oe_n_out, .irq_out);
    plc_pad_model pads (.oe_n_in(line_bits_oe_n_out), .level_in(line_bits_out), .ext_in(ext),
        .ext_en_in(ext_en), .pin_out(line_bits_in));
    initial forever #25 clk_in = ~clk_in;
    task automatic test_done();
        if (n_fail == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic acc(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d);
        wr_in <= w;
        rd_in <= r;
        addr_in <= a;
        wdata_in <= d;
        @(posedge clk_in);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        expq.push_back(e);
        acc(1'h0, 1'h1, a, 32'h0);
    endtask
    // Read data stands only in the cycle after the strobe
    always @(posedge clk_in)
    begin
        if (rd_q)
            chk(rdata_out, expq.pop_front());
        rd_q <= rd_in;
    end
    task automatic step(input logic [7:0] a, input logic [31:0] d, input logic [31:0] e, input logic [31:0] en);
        int j;
        logic [31:0] x;
        acc(1'h1, 1'h0, a, d);
        case (a)
            `PLC_OFF_OUTPUT_ENABLE_SET: oe |= d;
            `PLC_OFF_OUTPUT_ENABLE_CLEAR: oe &= ~d;
            `PLC_OFF_GLITCH_FILTER_ON: flt |= d;
            `PLC_OFF_GLITCH_FILTER_OFF: flt &= ~d;
            `PLC_OFF_DRIVE_LEVEL_HIGH: lvl |= d;
            `PLC_OFF_DRIVE_LEVEL_LOW: lvl &= ~d;
            `PLC_OFF_DRIVE_LEVEL_STATE: lvl = (lvl & ~dw) | (d & dw);
            `PLC_OFF_CHANGE_IRQ_ON: msk |= d;
            `PLC_OFF_CHANGE_IRQ_OFF: msk &= ~d;
            `PLC_OFF_OPEN_DRAIN_ON: od |= d;
            `PLC_OFF_OPEN_DRAIN_OFF: od &= ~d;
            `PLC_OFF_DIRECT_WRITE_ON: dw |= d;
            `PLC_OFF_DIRECT_WRITE_OFF: dw &= ~d;
            default: ;
        endcase
        ext <= e;
        ext_en <= en;
        repeat (10) acc(1'h0, 1'h0, 8'h00, 32'h0);
        oen = ~(oe & ~(od & lvl));
        outv = lvl & ~od;
        p = (~oen & outv) | (oen & ((en & e) | ~en));
        flg |= p ^ pin;
        pin = p;
        chk(line_bits_oe_n_out, oen);
        chk(line_bits_out, outv);
        chk({31'h0, irq_out}, {31'h0, |(flg & msk)});
        rd(`PLC_OFF_PIN_LEVEL_SAMPLE, pin);
        rd(`PLC_OFF_OUTPUT_ENABLE_STATE, oe);
        rd(`PLC_OFF_GLITCH_FILTER_STATE, flt);
        rd(`PLC_OFF_DRIVE_LEVEL_STATE, lvl);
        rd(`PLC_OFF_CHANGE_IRQ_MASK, msk);
        rd(`PLC_OFF_CHANGE_IRQ_FLAGS, flg);
        rd(`PLC_OFF_CHANGE_IRQ_FLAGS, 32'h0);
        rd(`PLC_OFF_OPEN_DRAIN_STATE, od);
        rd(`PLC_OFF_DIRECT_WRITE_PERMISSION_STATE, dw);
        // Readable offsets in the pool answer with their state, the rest with zero
        j = $urandom_range(15);
        x = (j == 6) ? lvl : ((j == 13) ? oe : 32'h0);
        rd(ops[j], x);
        flg = 32'h0;
        acc(1'h0, 1'h0, 8'h00, 32'h0);
    endtask
    initial
    begin
        #2000000;
        n_fail++;
        test_done();
    end
    initial
    begin
        void'($urandom(32'h7bd466f4));
        repeat (2) @(posedge clk_in);
        rst_n_in <= 1'h1;
        for (int i = 0; i < 80; i++)
            step(ops[$urandom_range(15)], $urandom(), $urandom(), $urandom());
        step(`PLC_OFF_OUTPUT_ENABLE_CLEAR, 32'hFFFFFFFF, 32'h0, 32'hFFFFFFFF);
        step(`PLC_OFF_GLITCH_FILTER_OFF, 32'hFFFFFFFF, 32'h0, 32'hFFFFFFFF);
        step(`PLC_OFF_GLITCH_FILTER_ON, 32'h1, 32'h0, 32'hFFFFFFFF);
        // Two-cycle pulse passes only the unfiltered line
        ext <= 32'h3;
        repeat (2) acc(1'h0, 1'h0, 8'h00, 32'h0);
        ext <= 32'h0;
        repeat (10) acc(1'h0, 1'h0, 8'h00, 32'h0);
        // Unmask the pending flag, then mask every line while it still stands
        acc(1'h1, 1'h0, `PLC_OFF_CHANGE_IRQ_ON, 32'h2);
        acc(1'h0, 1'h0, 8'h00, 32'h0);
        chk({31'h0, irq_out}, 32'h1);
        acc(1'h1, 1'h0, `PLC_OFF_CHANGE_IRQ_OFF, 32'hFFFFFFFF);
        acc(1'h0, 1'h0, 8'h00, 32'h0);
        chk({31'h0, irq_out}, 32'h0);
        msk = 32'h0;
        rd(`PLC_OFF_CHANGE_IRQ_FLAGS, 32'h2);
        repeat (3) acc(1'h0, 1'h0, 8'h00, 32'h0);
        test_done();
    end
endmodule
